// file: verilog/usb_frontend_pkg.sv
// Shared register map, field layout and line-state codes for the USB front-end register block.
package usb_frontend_pkg;

  // Byte offsets of the registers on the AXI4-Lite bus.
  localparam logic [7:0] OFF_DEVICE_ADDRESS    = 8'h08;
  localparam logic [7:0] OFF_LAST_PACKET_ID    = 8'h2c;
  localparam logic [7:0] OFF_LAST_ENDPOINT     = 8'h30;
  localparam logic [7:0] OFF_ENDPOINT_MASK     = 8'h34;
  localparam logic [7:0] OFF_SESSION_MASK      = 8'h38;
  localparam logic [7:0] OFF_POWER_SIGNALLING  = 8'h3c;
  localparam logic [7:0] OFF_TRANSCEIVER_CTRL  = 8'h40;
  localparam logic [7:0] OFF_IRQ_STATUS        = 8'h44;
  localparam logic [7:0] OFF_IRQ_MASK          = 8'h48;

  // Field positions and widths.
  localparam int ADDR_W           = 7;
  localparam int PID_W            = 4;
  localparam int EP_W             = 4;
  localparam int EP_VALID_BIT     = 4;
  localparam int EP_COUNT         = 16;
  localparam int POWER_W          = 9;
  localparam int CTL_PD_DIS_BIT   = 18;
  localparam int CTL_RES_SE0_BIT  = 13;
  localparam int CTL_RES_K_BIT    = 12;
  localparam int CTL_FILT_LSB     = 8;
  localparam int FILT_W           = 4;
  localparam int CTL_HW_RESUME    = 7;
  localparam int CTL_CONF_LSB     = 4;
  localparam int CONF_W           = 3;
  localparam int FILT_CNT_W       = 17;

  // Interrupt status and mask bit positions.
  localparam int IRQ_W            = 3;
  localparam int IRQ_TOKEN_BIT    = 0;
  localparam int IRQ_RES_SE0_BIT  = 1;
  localparam int IRQ_RES_K_BIT    = 2;

  // Special-endpoint marker ORed into the receive-port endpoint number.
  localparam logic [4:0] EP_SPECIAL_OR = 5'h10;

  // Full-speed line-state codes.
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_K   = 2'h2;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage : usb_frontend_pkg

// file: verilog/line_state_filter.sv
// Line-state glitch filter that passes a change only after it has been stable long enough.
`timescale 1ns/1ps
module line_state_filter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] line_raw,
  input  wire logic [3:0] log2_len,
  output logic      [1:0] line_filt
);

  logic [1:0]  filt_ff;
  logic [1:0]  nxt_filt;
  logic [1:0]  cand_ff;
  logic [1:0]  nxt_cand;
  logic [16:0] cnt_ff;
  logic [16:0] nxt_cnt;
  logic [16:0] thresh;

  // Counts consecutive cycles of one differing value; a new value restarts the count.
  always_comb begin
    thresh   = 17'h00001 << log2_len;
    nxt_filt = filt_ff;
    nxt_cand = line_raw;
    nxt_cnt  = 17'h00000;
    if (line_raw != filt_ff) begin
      if (line_raw != cand_ff) begin
        nxt_cnt = 17'h00001;
      end else begin
        nxt_cnt = cnt_ff + 17'h00001;
      end
      if (nxt_cnt >= thresh) begin
        nxt_filt = line_raw;
        nxt_cnt  = 17'h00000;
      end
    end
  end

  // Registers only; a reset line state of SE0 matches an unattached bus.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_ff <= 2'h0;
      cand_ff <= 2'h0;
      cnt_ff  <= 17'h00000;
    end else begin
      filt_ff <= nxt_filt;
      cand_ff <= nxt_cand;
      cnt_ff  <= nxt_cnt;
    end
  end

  assign line_filt = filt_ff;

endmodule : line_state_filter

// file: verilog/usb_frontend_regs.sv
// Token capture, endpoint marking and transceiver control registers behind an AXI4-Lite slave.
//
// Functional notes
// - Last received PID kept, read-only, resets zero.
// - Last token endpoint kept, read-only, resets zero.
// - Bit 4 flags a valid captured endpoint.
// - Masked endpoints reach receive port ORed 0x10.
// - Control bit 18 disables wide port pulldowns.
// - SE0 auto-resume sets bit 13 until cleared.
// - K auto-resume sets bit 12 until cleared.
// - Line change passes after 2^n stable cycles.
// - Bit 7 lets hardware handle suspend resume.
// - Bits 6:4 drive PHY configuration pins.
// - Only tokens to device address pass on.
`timescale 1ns/1ps
module usb_frontend_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        token_strobe,
  input  wire logic [3:0]  token_pid,
  input  wire logic [6:0]  token_addr,
  input  wire logic [3:0]  token_endpoint,
  input  wire logic        token_has_endpoint,
  input  wire logic [1:0]  line_state,
  input  wire logic        suspended,
  output logic [4:0]       rx_endpoint,
  output logic             rx_strobe,
  output logic             wide_port_a_pulldown_en,
  output logic             wide_port_b_pulldown_en,
  output logic [2:0]       phy_config_inputs,
  output logic [1:0]       line_state_filt,
  output logic             resume_pulse,
  output logic             irq
);

  // Merges one written word into a register under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Bus channel state.
  logic        aw_held_ff, nxt_aw_held;
  logic        w_held_ff, nxt_w_held;
  logic [7:0]  awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0]  wstrb_ff, nxt_wstrb;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic        rvalid_ff, nxt_rvalid;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        awready_ff, nxt_awready, wready_ff, nxt_wready, arready_ff, nxt_arready, do_write;
  // Register state.
  logic [6:0]  dev_addr_ff, nxt_dev_addr;
  logic [3:0]  pid_ff, nxt_pid;
  logic [3:0]  ep_ff, nxt_ep;
  logic        ep_valid_ff, nxt_ep_valid;
  logic [15:0] ep_mask_ff, nxt_ep_mask;
  logic [31:0] sess_mask_ff, nxt_sess_mask;
  logic [8:0]  power_ff, nxt_power;
  logic        pd_dis_ff, nxt_pd_dis, res_se0_ff, nxt_res_se0, res_k_ff, nxt_res_k;
  logic [3:0]  filt_len_ff, nxt_filt_len;
  logic        hw_resume_ff, nxt_hw_resume;
  logic [2:0]  conf_ff, nxt_conf;
  logic [2:0]  irq_stat_ff, nxt_irq_stat;
  logic [2:0]  irq_mask_ff, nxt_irq_mask;
  logic [4:0]  rx_ep_ff, nxt_rx_ep;
  logic        rx_strobe_ff, nxt_rx_strobe, resume_ff, nxt_resume, irq_ff, nxt_irq;
  logic [1:0]  filt_prev_ff, filt_now;
  logic        tok_hit, ev_se0, ev_k;
  logic [31:0] ctl_word, wmerged;
  // Line-state filter whose length comes from the control register.
  line_state_filter u_filter (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .line_raw  (line_state),
    .log2_len  (filt_len_ff),
    .line_filt (filt_now)
  );

  // Bus handshakes and the control word as software sees it; one write and one read at a time, beats in either order.
  always_comb begin
    ctl_word = usb_frontend_pkg::RST_ZERO;
    ctl_word[usb_frontend_pkg::CTL_PD_DIS_BIT]  = pd_dis_ff;
    ctl_word[usb_frontend_pkg::CTL_RES_SE0_BIT] = res_se0_ff;
    ctl_word[usb_frontend_pkg::CTL_RES_K_BIT]   = res_k_ff;
    ctl_word[usb_frontend_pkg::CTL_FILT_LSB +: usb_frontend_pkg::FILT_W] = filt_len_ff;
    ctl_word[usb_frontend_pkg::CTL_HW_RESUME]   = hw_resume_ff;
    ctl_word[usb_frontend_pkg::CTL_CONF_LSB +: usb_frontend_pkg::CONF_W] = conf_ff;
    nxt_aw_held = aw_held_ff;
    nxt_w_held  = w_held_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rresp   = rresp_ff;
    nxt_rdata   = rdata_ff;
    do_write    = 1'b0;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_held = 1'b1;
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb  = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (aw_held_ff && w_held_ff && !bvalid_ff) begin
      do_write    = 1'b1;
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      case (awaddr_ff)
        usb_frontend_pkg::OFF_DEVICE_ADDRESS, usb_frontend_pkg::OFF_LAST_PACKET_ID,
        usb_frontend_pkg::OFF_LAST_ENDPOINT, usb_frontend_pkg::OFF_ENDPOINT_MASK,
        usb_frontend_pkg::OFF_SESSION_MASK, usb_frontend_pkg::OFF_POWER_SIGNALLING,
        usb_frontend_pkg::OFF_TRANSCEIVER_CTRL, usb_frontend_pkg::OFF_IRQ_STATUS,
        usb_frontend_pkg::OFF_IRQ_MASK: nxt_bresp = usb_frontend_pkg::RESP_OKAY;
        default: nxt_bresp = usb_frontend_pkg::RESP_SLVERR;
      endcase
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = usb_frontend_pkg::RESP_OKAY;
      case (s_axi_araddr)
        usb_frontend_pkg::OFF_DEVICE_ADDRESS:   nxt_rdata = {25'h0000000, dev_addr_ff};
        usb_frontend_pkg::OFF_LAST_PACKET_ID:   nxt_rdata = {28'h0000000, pid_ff};
        usb_frontend_pkg::OFF_LAST_ENDPOINT:    nxt_rdata = {27'h0000000, ep_valid_ff, ep_ff};
        usb_frontend_pkg::OFF_ENDPOINT_MASK:    nxt_rdata = {16'h0000, ep_mask_ff};
        usb_frontend_pkg::OFF_SESSION_MASK:     nxt_rdata = sess_mask_ff;
        usb_frontend_pkg::OFF_POWER_SIGNALLING: nxt_rdata = {23'h000000, power_ff};
        usb_frontend_pkg::OFF_TRANSCEIVER_CTRL: nxt_rdata = ctl_word;
        usb_frontend_pkg::OFF_IRQ_STATUS:       nxt_rdata = {29'h00000000, irq_stat_ff};
        usb_frontend_pkg::OFF_IRQ_MASK:         nxt_rdata = {29'h00000000, irq_mask_ff};
        default: begin
          nxt_rdata = usb_frontend_pkg::RST_ZERO;
          nxt_rresp = usb_frontend_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Ready is withheld while a beat is held, so a second write cannot overtake the first.
    nxt_awready = !nxt_aw_held && !nxt_bvalid;
    nxt_wready  = !nxt_w_held && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  // Token capture, resume detection, register writes and interrupts.
  always_comb begin
    wmerged       = usb_frontend_pkg::RST_ZERO;
    nxt_dev_addr  = dev_addr_ff;
    nxt_pid       = pid_ff;
    nxt_ep        = ep_ff;
    nxt_ep_valid  = ep_valid_ff;
    nxt_ep_mask   = ep_mask_ff;
    nxt_sess_mask = sess_mask_ff;
    nxt_power     = power_ff;
    nxt_pd_dis    = pd_dis_ff;
    nxt_res_se0   = res_se0_ff;
    nxt_res_k     = res_k_ff;
    nxt_filt_len  = filt_len_ff;
    nxt_hw_resume = hw_resume_ff;
    nxt_conf      = conf_ff;
    nxt_irq_stat  = irq_stat_ff;
    nxt_irq_mask  = irq_mask_ff;
    nxt_rx_ep     = rx_ep_ff;
    nxt_rx_strobe = 1'b0;
    tok_hit = token_strobe && (token_addr == dev_addr_ff);
    ev_se0  = hw_resume_ff && suspended && (filt_now != filt_prev_ff) && (filt_now == usb_frontend_pkg::LS_SE0);
    ev_k    = hw_resume_ff && suspended && (filt_now != filt_prev_ff) && (filt_now == usb_frontend_pkg::LS_K);
    nxt_resume = ev_se0 || ev_k;
    if (do_write) begin
      case (awaddr_ff)
        usb_frontend_pkg::OFF_DEVICE_ADDRESS: begin
          wmerged      = merge({25'h0000000, dev_addr_ff}, wdata_ff, wstrb_ff);
          nxt_dev_addr = wmerged[usb_frontend_pkg::ADDR_W-1:0];
        end
        usb_frontend_pkg::OFF_ENDPOINT_MASK: begin
          wmerged     = merge({16'h0000, ep_mask_ff}, wdata_ff, wstrb_ff);
          nxt_ep_mask = wmerged[usb_frontend_pkg::EP_COUNT-1:0];
        end
        usb_frontend_pkg::OFF_SESSION_MASK: begin
          nxt_sess_mask = merge(sess_mask_ff, wdata_ff, wstrb_ff);
        end
        usb_frontend_pkg::OFF_POWER_SIGNALLING: begin
          wmerged   = merge({23'h000000, power_ff}, wdata_ff, wstrb_ff);
          nxt_power = wmerged[usb_frontend_pkg::POWER_W-1:0];
        end
        usb_frontend_pkg::OFF_TRANSCEIVER_CTRL: begin
          wmerged       = merge(ctl_word, wdata_ff, wstrb_ff);
          nxt_pd_dis    = wmerged[usb_frontend_pkg::CTL_PD_DIS_BIT];
          nxt_res_se0   = wmerged[usb_frontend_pkg::CTL_RES_SE0_BIT] && res_se0_ff;
          nxt_res_k     = wmerged[usb_frontend_pkg::CTL_RES_K_BIT] && res_k_ff;
          nxt_filt_len  = wmerged[usb_frontend_pkg::CTL_FILT_LSB +: usb_frontend_pkg::FILT_W];
          nxt_hw_resume = wmerged[usb_frontend_pkg::CTL_HW_RESUME];
          nxt_conf      = wmerged[usb_frontend_pkg::CTL_CONF_LSB +: usb_frontend_pkg::CONF_W];
        end
        usb_frontend_pkg::OFF_IRQ_STATUS: begin
          if (wstrb_ff[0]) begin
            nxt_irq_stat = irq_stat_ff & ~wdata_ff[usb_frontend_pkg::IRQ_W-1:0];
          end
        end
        usb_frontend_pkg::OFF_IRQ_MASK: begin
          if (wstrb_ff[0]) begin
            nxt_irq_mask = wdata_ff[usb_frontend_pkg::IRQ_W-1:0];
          end
        end
        default: wmerged = usb_frontend_pkg::RST_ZERO;
      endcase
    end
    // Hardware events come last so that a set in the same cycle as a clear wins.
    if (tok_hit) begin
      nxt_pid       = token_pid;
      nxt_ep        = token_has_endpoint ? token_endpoint : 4'h0;
      nxt_ep_valid  = token_has_endpoint;
      nxt_rx_ep     = ep_mask_ff[token_endpoint] ? ({1'b0, token_endpoint} | usb_frontend_pkg::EP_SPECIAL_OR)
                                                 : {1'b0, token_endpoint};
      nxt_rx_strobe = token_has_endpoint;
      nxt_irq_stat[usb_frontend_pkg::IRQ_TOKEN_BIT] = 1'b1;
    end
    if (ev_se0) begin
      nxt_res_se0 = 1'b1;
      nxt_irq_stat[usb_frontend_pkg::IRQ_RES_SE0_BIT] = 1'b1;
    end
    if (ev_k) begin
      nxt_res_k = 1'b1;
      nxt_irq_stat[usb_frontend_pkg::IRQ_RES_K_BIT] = 1'b1;
    end
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
  end
  // State registers only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;  w_held_ff <= 1'b0;  awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;  wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;  bresp_ff <= 2'h0;  rvalid_ff <= 1'b0;  rresp_ff <= 2'h0;
      rdata_ff <= 32'h00000000;
      awready_ff <= 1'b0;  wready_ff <= 1'b0;  arready_ff <= 1'b0;
      dev_addr_ff <= 7'h00;  pid_ff <= 4'h0;  ep_ff <= 4'h0;  ep_valid_ff <= 1'b0;
      ep_mask_ff <= 16'h0000;  sess_mask_ff <= 32'h00000000;  power_ff <= 9'h000;
      pd_dis_ff <= 1'b0;  res_se0_ff <= 1'b0;  res_k_ff <= 1'b0;  filt_len_ff <= 4'h0;
      hw_resume_ff <= 1'b0;  conf_ff <= 3'h0;  irq_stat_ff <= 3'h0;  irq_mask_ff <= 3'h0;
      rx_ep_ff <= 5'h00;  rx_strobe_ff <= 1'b0;  resume_ff <= 1'b0;  irq_ff <= 1'b0;
      filt_prev_ff <= 2'h0;
    end else begin
      aw_held_ff <= nxt_aw_held;  w_held_ff <= nxt_w_held;  awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;  wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;  bresp_ff <= nxt_bresp;  rvalid_ff <= nxt_rvalid;  rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      awready_ff <= nxt_awready;  wready_ff <= nxt_wready;  arready_ff <= nxt_arready;
      dev_addr_ff <= nxt_dev_addr;  pid_ff <= nxt_pid;  ep_ff <= nxt_ep;  ep_valid_ff <= nxt_ep_valid;
      ep_mask_ff <= nxt_ep_mask;  sess_mask_ff <= nxt_sess_mask;  power_ff <= nxt_power;
      pd_dis_ff <= nxt_pd_dis;  res_se0_ff <= nxt_res_se0;  res_k_ff <= nxt_res_k;  filt_len_ff <= nxt_filt_len;
      hw_resume_ff <= nxt_hw_resume;  conf_ff <= nxt_conf;  irq_stat_ff <= nxt_irq_stat;  irq_mask_ff <= nxt_irq_mask;
      rx_ep_ff <= nxt_rx_ep;  rx_strobe_ff <= nxt_rx_strobe;  resume_ff <= nxt_resume;  irq_ff <= nxt_irq;
      filt_prev_ff <= filt_now;
    end
  end

  // Outputs straight from flip-flops; the filtered state is a register inside the filter.
  assign s_axi_awready           = awready_ff;
  assign s_axi_wready            = wready_ff;
  assign s_axi_bvalid            = bvalid_ff;
  assign s_axi_bresp             = bresp_ff;
  assign s_axi_arready           = arready_ff;
  assign s_axi_rvalid            = rvalid_ff;
  assign s_axi_rresp             = rresp_ff;
  assign s_axi_rdata             = rdata_ff;
  assign rx_endpoint             = rx_ep_ff;
  assign rx_strobe               = rx_strobe_ff;
  assign wide_port_a_pulldown_en = !pd_dis_ff;
  assign wide_port_b_pulldown_en = !pd_dis_ff;
  assign phy_config_inputs       = conf_ff;
  assign line_state_filt         = filt_now;
  assign resume_pulse            = resume_ff;
  assign irq                     = irq_ff;

  // Checks on the captured token fields and control outputs.
  a_pid_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    tok_hit |=> (pid_ff == $past(token_pid))) else $error("packet id not captured");
  a_ep_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    (tok_hit && token_has_endpoint) |=> (ep_ff == $past(token_endpoint)) && ep_valid_ff)
    else $error("endpoint not captured");
  a_ep_valid_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    (tok_hit && !token_has_endpoint) |=> !ep_valid_ff) else $error("endpoint valid left set");
  a_special_ep: assert property (@(posedge aclk) disable iff (!aresetn)
    tok_hit |=> (rx_ep_ff[4] == $past(ep_mask_ff[token_endpoint])) && (rx_ep_ff[3:0] == $past(token_endpoint)))
    else $error("special endpoint marker wrong");
  a_pulldown_ctl: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && (awaddr_ff == usb_frontend_pkg::OFF_TRANSCEIVER_CTRL) &&
    wstrb_ff[usb_frontend_pkg::CTL_PD_DIS_BIT / 8]) |=>
    (wide_port_a_pulldown_en == !$past(wdata_ff[usb_frontend_pkg::CTL_PD_DIS_BIT])) &&
    (wide_port_a_pulldown_en == wide_port_b_pulldown_en)) else $error("pulldown enable mismatch");
  a_se0_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (res_se0_ff && !do_write) |=> res_se0_ff) else $error("se0 resume flag lost");
  a_k_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_k |=> res_k_ff && resume_ff) else $error("k resume flag not set");
  a_addr_filter: assert property (@(posedge aclk) disable iff (!aresetn)
    (token_strobe && token_addr != dev_addr_ff) |=> !rx_strobe_ff && $stable(pid_ff))
    else $error("foreign token passed on");
  a_no_hw_resume: assert property (@(posedge aclk) disable iff (!aresetn)
    (!hw_resume_ff && !do_write) |=> !resume_ff && $stable(res_se0_ff) && $stable(res_k_ff))
    else $error("resume without hardware handling");

endmodule : usb_frontend_regs

// file: tb/usb_line_model.sv
// Behavioural model of the transceiver and host side that feeds decoded tokens and line state.
`timescale 1ns/1ps
module usb_line_model (
  input  wire logic aclk,
  output logic       token_strobe = 1'b0,
  output logic [3:0] token_pid = 4'h0,
  output logic [6:0] token_addr = 7'h00,
  output logic [3:0] token_endpoint = 4'h0,
  output logic       token_has_endpoint = 1'b0,
  output logic [1:0] line_state = 2'h1,
  output logic       suspended = 1'b0
);
  // One token for one cycle; the fields are inverted afterwards so that stale values are never trusted.
  task automatic send(input logic [3:0] p, input logic [6:0] a, input logic [3:0] e, input logic h);
    token_strobe       <= 1'b1;
    token_pid          <= p;
    token_addr         <= a;
    token_endpoint     <= e;
    token_has_endpoint <= h;
    @(posedge aclk);
    token_strobe       <= 1'b0;
    token_pid          <= ~p;
    token_addr         <= ~a;
    token_endpoint     <= ~e;
    token_has_endpoint <= ~h;
  endtask : send

  // The line is held steady after a change, as a host keeps resume signalling on the bus.
  task automatic set(input logic [1:0] l, input logic s);
    line_state <= l;
    suspended  <= s;
  endtask : set
endmodule : usb_line_model

// file: tb/usb_token_capture_phy_ctrl_tb.sv
// Self-checking bench for the token capture and transceiver control registers.
`timescale 1ns/1ps
module usb_token_capture_phy_ctrl_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic [3:0]  wstrb = 4'hf;
  logic [31:0] rdata;
  logic [1:0]  bresp, rresp, ls, lsf;
  logic        awready, wready, bvalid, arready, rvalid, tstb, thas, susp, rxs, rpulse, irq, pda, pdb;
  logic [3:0]  pid, ep;
  logic [6:0]  tadr;
  logic [4:0]  rxep;
  logic [2:0]  conf;
  int          bad_count = 0;
  int          checks_done = 0;

  // Ready signals are held high; the slave decides when a response is taken.
  usb_frontend_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .token_strobe(tstb),
    .token_pid(pid), .token_addr(tadr), .token_endpoint(ep), .token_has_endpoint(thas), .line_state(ls),
    .suspended(susp), .rx_endpoint(rxep), .rx_strobe(rxs), .wide_port_a_pulldown_en(pda),
    .wide_port_b_pulldown_en(pdb), .phy_config_inputs(conf), .line_state_filt(lsf),
    .resume_pulse(rpulse), .irq(irq));

  usb_line_model u_line (.aclk(aclk), .token_strobe(tstb), .token_pid(pid), .token_addr(tadr),
    .token_endpoint(ep), .token_has_endpoint(thas), .line_state(ls), .suspended(susp));

  // Free-running core clock.
  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // Both beats are offered together and each is dropped at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) return;
    end
    bad_count++;
    end_sim();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        return;
      end
    end
    bad_count++;
    end_sim();
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, d, exp);
  endtask : rchk

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rchk(8'h2c, 32'h0, "pid reset");
    rchk(8'h30, 32'h0, "ep reset");
    rchk(8'h40, 32'h0, "ctl reset");
    chk("pulldowns", {pda, pdb}, 2'h3);
    rd(8'h80, d, r);
    chk("unmapped", {d[29:0], r}, 32'h2);
    $display("test reset done");
  endtask : t_reset

  // Byte lanes and plain words, then marked endpoint 3, a foreign address, no endpoint and an unmarked endpoint.
  task automatic t_token;
    wstrb <= 4'h1;
    wr(8'h3c, 32'hffff_ffff);
    wstrb <= 4'hf;
    rchk(8'h3c, 32'h0000_00ff, "power lane");
    wr(8'h3c, 32'hffff_ffff);
    rchk(8'h3c, 32'h0000_01ff, "power full");
    wr(8'h38, 32'ha5a5_5a5a);
    rchk(8'h38, 32'ha5a5_5a5a, "session mask");
    wr(8'h08, 32'h5);
    wr(8'h34, 32'h8);
    wr(8'h48, 32'h1);
    u_line.send(4'h9, 7'h05, 4'h3, 1'b1);
    @(posedge aclk);
    chk("rx marked", {rxs, rxep}, 6'h33);
    @(posedge aclk);
    chk("irq set", irq, 1'b1);
    rchk(8'h2c, 32'h9, "pid");
    rchk(8'h30, 32'h13, "ep");
    u_line.send(4'h4, 7'h06, 4'h7, 1'b1);
    @(posedge aclk);
    chk("rx foreign", rxs, 1'b0);
    rchk(8'h2c, 32'h9, "pid foreign");
    u_line.send(4'h5, 7'h05, 4'h2, 1'b0);
    rchk(8'h30, 32'h0, "ep none");
    u_line.send(4'h1, 7'h05, 4'h2, 1'b1);
    @(posedge aclk);
    chk("rx plain", {rxs, rxep}, 6'h22);
    wr(8'h2c, 32'hf);
    rchk(8'h2c, 32'h1, "pid ro");
    wr(8'h44, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq clear", irq, 1'b0);
    $display("test token done");
  endtask : t_token

  // K resume then SE0 reset signalling while suspended, filter length four cycles.
  task automatic t_ctl;
    int n;
    wr(8'h40, 32'h0004_02d0);
    @(posedge aclk);
    chk("ctl pins", {pda, pdb, conf}, 5'h05);
    for (int i = 0; i < 2; i++) begin
      u_line.set(i ? 2'h0 : 2'h2, 1'b1);
      repeat (3) @(posedge aclk);
      chk("filter early", lsf, i ? 2'h2 : 2'h1);
      n = 0;
      while (rpulse !== 1'b1 && n < 20) begin
        @(posedge aclk);
        n++;
      end
      if (n == 20) begin
        bad_count++;
        end_sim();
      end
      chk("filtered", lsf, i ? 2'h0 : 2'h2);
      rchk(8'h40, 32'h0004_02d0 | (32'h0000_1000 << i), "flag set");
      wr(8'h40, 32'h0004_02d0);
      rchk(8'h40, 32'h0004_02d0, "flag clear");
    end
    rchk(8'h44, 32'h0000_0006, "resume status");
    wr(8'h40, 32'h0004_0050);
    u_line.set(2'h2, 1'b1);
    repeat (8) @(posedge aclk);
    chk("polled line", lsf, 2'h2);
    rchk(8'h40, 32'h0004_0050, "sw resume");
    $display("test ctl done");
  endtask : t_ctl

  // Reset, then the scenarios, then the verdict.
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_token();
    t_ctl();
    end_sim();
  end
endmodule : usb_token_capture_phy_ctrl_tb
